// >>> verilog/aurb_pkg.sv
package aurb_pkg;
  // ==========================================================================
  // register map
  localparam logic [3:0] ADDR_FLAGS_ZERO = 4'h0;
  localparam logic [3:0] ADDR_FLAGS_ONE  = 4'h1;
  localparam logic [3:0] ADDR_INSTANT    = 4'h2;
  localparam logic [3:0] ADDR_X_HIGH     = 4'h3;
  localparam logic [3:0] ADDR_X_LOW      = 4'h4;
  localparam logic [3:0] ADDR_Y_HIGH     = 4'h5;
  localparam logic [3:0] ADDR_Y_LOW      = 4'h6;
  localparam logic [3:0] ADDR_Z_HIGH     = 4'h7;
  localparam logic [3:0] ADDR_Z_LOW      = 4'h8;
  localparam logic [3:0] ADDR_TEMP       = 4'h9;
  localparam logic [3:0] ADDR_MASK_ZERO  = 4'hA;
  localparam logic [3:0] ADDR_MASK_ONE   = 4'hB;
  localparam logic [3:0] ADDR_DETECTION  = 4'hC;
  // ==========================================================================
  // field positions
  localparam int BIT_SOFT_RESET = 4;
  localparam int BIT_NEW_SAMPLE = 0;
  localparam int BIT_XY_CHANGE  = 6;
  localparam int BIT_Z_CHANGE   = 7;
  // ==========================================================================
  // reset values and constants
  localparam logic [7:0]  RESET_BYTE    = 8'h00;
  localparam logic [3:0]  SHAKE_CLR_MSK = 4'hF;
  localparam logic [7:0]  ZERO_NIBBLE   = 8'h00;
  localparam logic [11:0] ZERO_ACCEL    = 12'h000;
  // 0.375g at 1024 LSB/g
  localparam logic [11:0] XY_VALID_LSB  = 12'h180;
  localparam logic [7:0]  COUNT_BASE    = 8'h10;
  localparam logic [7:0]  COUNT_ONE     = 8'h01;
  // ==========================================================================
  // orientation filter states
  typedef enum logic [1:0] {
    FLT_IDLE  = 2'b01,
    FLT_COUNT = 2'b10
  } aurb_flt_t;
endpackage : aurb_pkg

// >>> verilog/aurb_register_bank.sv
// What this block does
// R1 - byte registers at addresses zero-twelve; thirteen-fifteen read zero
// R2 - addresses zero, one: read flags, write clears
// R3 - events set flags, sticky until cleared
// R4 - write one clears flag; zero leaves it
// R5 - flag zero bits zero-three: shake directions
// R6 - set shake flag blocks further axis detection
// R7 - bits six, seven: xy and z change
// R8 - filtered xy code in bits five-four
// R9 - xy updates only above 0.375g magnitude
// R10 - bits seven-six: tilt flag and z sign
// R11 - tilt sets flag, freezes xy updates
// R12 - commit orientation after consecutive valid readings
// R13 - bit zero set on new measurement
// R14 - soft reset bit resets core during transfer
// R15 - register two holds instantaneous orientation codes
// R16 - calibration loaded bit sticks at one
// R17 - x split across registers three, four
// R18 - y and z share x layout
// R19 - register nine holds temperature byte
// R20 - count code picks 16/32/64/128 readings
// R21 - active-low interrupt from masked flags
// R22 - address pointer advances after each byte
// R23 - constant zero flag bits read zero
// R24 - flags set regardless of masks
module aurb_register_bank (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        busActive,
  input  wire logic        addrLoad,
  input  wire logic [7:0]  addrByte,
  input  wire logic        writeStrobe,
  input  wire logic [7:0]  writeData,
  input  wire logic        readStrobe,
  output logic      [7:0]  readData,
  input  wire logic        sampleValid,
  input  wire logic [11:0] xSample,
  input  wire logic [11:0] ySample,
  input  wire logic [11:0] zSample,
  input  wire logic [7:0]  tempSample,
  input  wire logic [3:0]  shakeDetect,
  input  wire logic        calibDone,
  output logic             irqOut,
  output logic             irqOutEn,
  output logic             softResetActive
);
  // ==========================================================================
  // helpers
  function automatic logic [11:0] absVal(input logic [11:0] v);
    absVal = v[11] ? 12'(-v) : v;
  endfunction : absVal

  function automatic logic [7:0] splitLow(input logic [11:0] v);
    splitLow = {v[3:0], aurb_pkg::ZERO_NIBBLE[3:0]};
  endfunction : splitLow

  // one write decode shared by clears, masks, detection and soft reset
  function automatic logic wrHit(input logic       strobe,
                                 input logic [3:0] ptr,
                                 input logic [3:0] addr);
    wrHit = strobe && (ptr == addr);
  endfunction : wrHit

  // ==========================================================================
  // soft reset holds the core while the transfer lasts
  logic [3:0] ptr_reg;
  logic [3:0] ptr_next;
  logic       softRst_reg;
  logic       softRst_next;
  logic       coreRst;
  always_comb begin
    softRst_next = softRst_reg;
    // R14 soft reset hold
    if (wrHit(writeStrobe, ptr_reg, aurb_pkg::ADDR_FLAGS_ONE)
        && writeData[aurb_pkg::BIT_SOFT_RESET])
      softRst_next = 1'b1;
    else if (!busActive)
      softRst_next = 1'b0;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) softRst_reg <= 1'b0;
    else          softRst_reg <= softRst_next;
  end
  assign coreRst         = softRst_reg;
  assign softResetActive = softRst_reg;

  // ==========================================================================
  // address pointer, kept out of soft reset so the transfer completes
  // a burst past fifteen wraps back to zero
  always_comb begin
    ptr_next = ptr_reg;
    // R1 four-bit decode
    if (addrLoad) ptr_next = addrByte[3:0];
    // R22 pointer advance
    else if (writeStrobe || readStrobe) ptr_next = 4'(ptr_reg + 4'h1);
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) ptr_reg <= 4'h0;
    else          ptr_reg <= ptr_next;
  end

  // ==========================================================================
  // core state
  logic [7:0]          flagsZero_reg;
  logic [7:0]          flagsZero_next;
  logic                newSample_reg;
  logic                newSample_next;
  logic [7:0]          maskZero_reg;
  logic [7:0]          maskZero_next;
  logic [7:0]          maskOne_reg;
  logic [7:0]          maskOne_next;
  logic [7:0]          detect_reg;
  logic [7:0]          detect_next;
  logic [11:0]         x_reg;
  logic [11:0]         x_next;
  logic [11:0]         y_reg;
  logic [11:0]         y_next;
  logic [11:0]         z_reg;
  logic [11:0]         z_next;
  logic [7:0]          temp_reg;
  logic [7:0]          temp_next;
  logic                calib_reg;
  logic                calib_next;
  logic [1:0]          fXy_reg;
  logic [1:0]          fXy_next;
  logic [1:0]          fZ_reg;
  logic [1:0]          fZ_next;
  logic [1:0]          candXy_reg;
  logic [1:0]          candXy_next;
  logic [1:0]          candZ_reg;
  logic [1:0]          candZ_next;
  logic [7:0]          cnt_reg;
  logic [7:0]          cnt_next;
  aurb_pkg::aurb_flt_t flt_reg;
  aurb_pkg::aurb_flt_t flt_next;
  logic [1:0]          iXy_reg;
  logic [1:0]          iXy_next;
  logic [1:0]          iZ_reg;
  logic [1:0]          iZ_next;

  logic        wrClear0;
  logic        wrClear1;
  logic [11:0] ax;
  logic [11:0] ay;
  logic        xyValid;
  logic [1:0]  measXy;
  logic [1:0]  measZ;
  logic [7:0]  needCount;
  logic [3:0]  shakeSet;

  assign wrClear0 = wrHit(writeStrobe, ptr_reg, aurb_pkg::ADDR_FLAGS_ZERO);
  assign wrClear1 = wrHit(writeStrobe, ptr_reg, aurb_pkg::ADDR_FLAGS_ONE);
  assign ax       = absVal(xSample);
  assign ay       = absVal(ySample);
  // R9 magnitude threshold
  assign xyValid  = (ax > aurb_pkg::XY_VALID_LSB) || (ay > aurb_pkg::XY_VALID_LSB);
  // R8 xy encoding
  assign measXy   = (ax >= ay) ? {xSample[11], 1'b0} : {ySample[11], 1'b1};
  // R10 tilt and sign
  // R11 tilt from xy magnitude at or below threshold
  assign measZ    = {!xyValid, zSample[11]};
  // R20 count select
  assign needCount = 8'(aurb_pkg::COUNT_BASE << detect_reg[1:0]);
  // R6 block while flag set
  assign shakeSet = shakeDetect & ~flagsZero_reg[3:0];

  // ==========================================================================
  // next state of flags, samples and orientation filter
  always_comb begin
    flagsZero_next = flagsZero_reg;
    newSample_next = newSample_reg;
    maskZero_next  = maskZero_reg;
    maskOne_next   = maskOne_reg;
    detect_next    = detect_reg;
    x_next = x_reg;
    y_next = y_reg;
    z_next = z_reg;
    temp_next   = temp_reg;
    calib_next  = calib_reg;
    fXy_next    = fXy_reg;
    fZ_next     = fZ_reg;
    candXy_next = candXy_reg;
    candZ_next  = candZ_reg;
    cnt_next    = cnt_reg;
    flt_next    = flt_reg;
    iXy_next    = iXy_reg;
    iZ_next     = iZ_reg;
    // R4 clear by writing one
    if (wrClear0) flagsZero_next = flagsZero_reg & ~writeData;
    if (wrClear1 && writeData[aurb_pkg::BIT_NEW_SAMPLE]) newSample_next = 1'b0;
    if (wrHit(writeStrobe, ptr_reg, aurb_pkg::ADDR_MASK_ZERO)) maskZero_next = writeData;
    if (wrHit(writeStrobe, ptr_reg, aurb_pkg::ADDR_MASK_ONE))  maskOne_next  = writeData;
    if (wrHit(writeStrobe, ptr_reg, aurb_pkg::ADDR_DETECTION)) detect_next   = writeData;
    // R16 sticky calibration
    if (calibDone) calib_next = 1'b1;
    // R5 shake flags
    // R3 sticky set; a clear of a set flag wins over a same-cycle shake
    // R24 set ignores masks
    flagsZero_next[3:0] = flagsZero_next[3:0] | shakeSet;
    if (sampleValid) begin
      // R13 new sample flag
      newSample_next = 1'b1;
      x_next    = xSample;
      y_next    = ySample;
      z_next    = zSample;
      temp_next = tempSample;
      // R15 instantaneous codes
      if (xyValid) iXy_next = measXy;
      iZ_next = measZ;
      // R12 consecutive filter
      case (flt_reg)
        aurb_pkg::FLT_IDLE: begin
          if ((xyValid && measXy != fXy_reg) || measZ != fZ_reg) begin
            candXy_next = xyValid ? measXy : fXy_reg;
            candZ_next  = measZ;
            cnt_next    = aurb_pkg::COUNT_ONE;
            flt_next    = aurb_pkg::FLT_COUNT;
          end
        end
        aurb_pkg::FLT_COUNT: begin
          if (measZ != candZ_reg || (xyValid && measXy != candXy_reg)) begin
            flt_next = aurb_pkg::FLT_IDLE;
          end else if (8'(cnt_reg + aurb_pkg::COUNT_ONE) >= needCount) begin
            // R7 change flags
            if (candXy_reg != fXy_reg) flagsZero_next[aurb_pkg::BIT_XY_CHANGE] = 1'b1;
            if (candZ_reg != fZ_reg)   flagsZero_next[aurb_pkg::BIT_Z_CHANGE]  = 1'b1;
            fXy_next = candXy_reg;
            fZ_next  = candZ_reg;
            flt_next = aurb_pkg::FLT_IDLE;
          end else begin
            cnt_next = 8'(cnt_reg + aurb_pkg::COUNT_ONE);
          end
        end
        default: flt_next = aurb_pkg::FLT_IDLE;
      endcase
    end
    // R23 reserved zeros
    flagsZero_next[5:4] = 2'b00;
  end

  // ==========================================================================
  // core registers: soft reset clears them as power-up does
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flagsZero_reg <= aurb_pkg::RESET_BYTE;
      newSample_reg <= 1'b0;
      maskZero_reg  <= aurb_pkg::RESET_BYTE;
      maskOne_reg   <= aurb_pkg::RESET_BYTE;
      detect_reg    <= aurb_pkg::RESET_BYTE;
      x_reg <= aurb_pkg::ZERO_ACCEL;
      y_reg <= aurb_pkg::ZERO_ACCEL;
      z_reg <= aurb_pkg::ZERO_ACCEL;
      temp_reg <= aurb_pkg::RESET_BYTE;
      calib_reg <= 1'b0;
      fXy_reg <= 2'b00;
      fZ_reg <= 2'b00;
      candXy_reg <= 2'b00;
      candZ_reg <= 2'b00;
      cnt_reg <= aurb_pkg::RESET_BYTE;
      flt_reg <= aurb_pkg::FLT_IDLE;
      iXy_reg <= 2'b00;
      iZ_reg <= 2'b00;
    end else if (coreRst) begin
      flagsZero_reg <= aurb_pkg::RESET_BYTE;
      newSample_reg <= 1'b0;
      maskZero_reg  <= aurb_pkg::RESET_BYTE;
      maskOne_reg   <= aurb_pkg::RESET_BYTE;
      detect_reg    <= aurb_pkg::RESET_BYTE;
      x_reg <= aurb_pkg::ZERO_ACCEL;
      y_reg <= aurb_pkg::ZERO_ACCEL;
      z_reg <= aurb_pkg::ZERO_ACCEL;
      temp_reg <= aurb_pkg::RESET_BYTE;
      calib_reg <= 1'b0;
      fXy_reg <= 2'b00;
      fZ_reg <= 2'b00;
      candXy_reg <= 2'b00;
      candZ_reg <= 2'b00;
      cnt_reg <= aurb_pkg::RESET_BYTE;
      flt_reg <= aurb_pkg::FLT_IDLE;
      iXy_reg <= 2'b00;
      iZ_reg <= 2'b00;
    end else begin
      flagsZero_reg <= flagsZero_next;
      newSample_reg <= newSample_next;
      maskZero_reg  <= maskZero_next;
      maskOne_reg   <= maskOne_next;
      detect_reg    <= detect_next;
      x_reg <= x_next;
      y_reg <= y_next;
      z_reg <= z_next;
      temp_reg <= temp_next;
      calib_reg <= calib_next;
      fXy_reg <= fXy_next;
      fZ_reg <= fZ_next;
      candXy_reg <= candXy_next;
      candZ_reg <= candZ_next;
      cnt_reg <= cnt_next;
      flt_reg <= flt_next;
      iXy_reg <= iXy_next;
      iZ_reg <= iZ_next;
    end
  end

  // ==========================================================================
  // read mux, registered so the byte is stable while shifted out
  logic [7:0] rd_reg, rd_next;
  logic [7:0] flagsOne;
  // R23 zero bits three-one
  assign flagsOne = {fZ_reg, fXy_reg, 3'b000, newSample_reg};
  always_comb begin
    // R2 flags on read
    // R17 x split
    // R18 y and z split
    // R19 temperature
    case (ptr_next)
      aurb_pkg::ADDR_FLAGS_ZERO: rd_next = flagsZero_reg;
      aurb_pkg::ADDR_FLAGS_ONE:  rd_next = flagsOne;
      aurb_pkg::ADDR_INSTANT:    rd_next = {3'b000, calib_reg, iZ_reg, iXy_reg};
      aurb_pkg::ADDR_X_HIGH:     rd_next = x_reg[11:4];
      aurb_pkg::ADDR_X_LOW:      rd_next = splitLow(x_reg);
      aurb_pkg::ADDR_Y_HIGH:     rd_next = y_reg[11:4];
      aurb_pkg::ADDR_Y_LOW:      rd_next = splitLow(y_reg);
      aurb_pkg::ADDR_Z_HIGH:     rd_next = z_reg[11:4];
      aurb_pkg::ADDR_Z_LOW:      rd_next = splitLow(z_reg);
      aurb_pkg::ADDR_TEMP:       rd_next = temp_reg;
      aurb_pkg::ADDR_DETECTION:  rd_next = detect_reg;
      default:                   rd_next = aurb_pkg::RESET_BYTE;
    endcase
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) rd_reg <= aurb_pkg::RESET_BYTE;
    else          rd_reg <= rd_next;
  end
  assign readData = rd_reg;

  // ==========================================================================
  // open-drain interrupt: enable low pulls the pin low
  logic irqAny;
  // R21 masked interrupt
  assign irqAny   = |(flagsZero_reg & maskZero_reg) | (newSample_reg & maskOne_reg[0]);
  assign irqOut   = 1'b0;
  assign irqOutEn = !irqAny;
endmodule : aurb_register_bank

// >>> testbench/aurb_register_bank_checker.sv
module aurb_register_bank_checker (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       busActive,
  input wire logic       addrLoad,
  input wire logic [7:0] addrByte,
  input wire logic       writeStrobe,
  input wire logic [7:0] writeData,
  input wire logic       readStrobe,
  input wire logic [7:0] readData,
  input wire logic       irqOut,
  input wire logic       softResetActive
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // ==========
  // read-back
  a_unmapped_id_zero: assert property (
    addrLoad && addrByte[3:1] == 3'h7 |=> readData == 8'h00) else $error("id reg not zero");
  a_flags_one_gap: assert property (
    addrLoad && addrByte[3:0] == 4'h0 ##1 readStrobe && !addrLoad |=> readData[3:1] == 3'h0)
    else $error("flag gap bits set");
  a_instant_top_zero: assert property (
    addrLoad && addrByte[3:0] == 4'h2 |=> readData[7:5] == 3'h0) else $error("status top set");
  a_low_nibble_zero: assert property (
    addrLoad && addrByte[3:0] == 4'h2 ##1 (readStrobe && !addrLoad) [*2]
    |=> readData[3:0] == 4'h0) else $error("low nibble not zero");
  a_calib_sticks: assert property (
    addrLoad && addrByte[3:0] == 4'h2 ##1 readData[4] && !addrLoad && !readStrobe
    && !writeStrobe && !softResetActive |=> readData[4]) else $error("calib flag dropped");
  // ==========
  // soft reset, pin
  a_soft_reset_start: assert property (
    addrLoad && addrByte[3:0] == 4'h1 ##1 writeStrobe && writeData[4] && !addrLoad
    |=> softResetActive) else $error("soft reset missed");
  a_soft_reset_cause: assert property (
    $rose(softResetActive) |-> $past(writeStrobe) && $past(writeData[4]))
    else $error("soft reset uncaused");
  a_soft_reset_ends: assert property (
    softResetActive && !busActive |-> ##[1:2] !softResetActive) else $error("soft reset stuck");
  a_irq_data_low: assert property (irqOut == 1'b0) else $error("irq data high");
  c_soft_reset: cover property ($rose(softResetActive));
  c_burst: cover property (readStrobe [*3]);
  c_clear: cover property (writeStrobe && writeData == 8'h05);
endmodule : aurb_register_bank_checker

bind aurb_register_bank aurb_register_bank_checker aurb_register_bank_checker_i (
  .clk(clk), .reset_n(reset_n), .busActive(busActive), .addrLoad(addrLoad),
  .addrByte(addrByte), .writeStrobe(writeStrobe), .writeData(writeData),
  .readStrobe(readStrobe), .readData(readData), .irqOut(irqOut),
  .softResetActive(softResetActive));

// >>> testbench/aurb_host_model.sv
module aurb_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] readData,
  output logic            busActive,
  output logic            addrLoad,
  output logic      [7:0] addrByte,
  output logic            writeStrobe,
  output logic      [7:0] writeData,
  output logic            readStrobe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got [16];
  initial begin
    {busActive, addrLoad, writeStrobe, readStrobe} = 4'h0;
    {addrByte, writeData} = 16'h0000;
  end
  task automatic xfer(input logic [3:0] a, input int n, input logic wr, input logic [7:0] d);
    @(negedge clk);
    busActive = 1'b1;
    addrLoad  = 1'b1;
    addrByte  = {4'h0, a};
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      addrLoad    = 1'b0;
      got[i]      = readData;
      readStrobe  = !wr && (i < n - 1);
      writeStrobe = wr;
      writeData   = d;
    end
    @(negedge clk);
    {busActive, readStrobe, writeStrobe} = 3'h0;
    // released lines toggle so stale data never looks valid
    addrByte  = ~addrByte;
    writeData = ~writeData;
  endtask : xfer
endmodule : aurb_host_model

// >>> testbench/aurb_register_bank_bench.sv
`define CHK(g, e) begin totalChecks++; if ((g) !== (e)) begin miscompares++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module aurb_register_bank_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, reset_n, busActive, addrLoad, writeStrobe, readStrobe;
  logic        sampleValid, calibDone, irqOut, irqOutEn, softResetActive;
  logic [7:0]  addrByte, writeData, readData, tempSample;
  logic [11:0] xSample, ySample, zSample;
  logic [3:0]  shakeDetect;
  int          totalChecks, miscompares, cycles;
  aurb_register_bank aurb_register_bank_i (.clk(clk), .reset_n(reset_n),
    .busActive(busActive), .addrLoad(addrLoad), .addrByte(addrByte),
    .writeStrobe(writeStrobe), .writeData(writeData), .readStrobe(readStrobe),
    .readData(readData), .sampleValid(sampleValid), .xSample(xSample), .ySample(ySample),
    .zSample(zSample), .tempSample(tempSample), .shakeDetect(shakeDetect),
    .calibDone(calibDone), .irqOut(irqOut), .irqOutEn(irqOutEn),
    .softResetActive(softResetActive));
  aurb_host_model aurb_host_model_i (.clk(clk), .readData(readData), .busActive(busActive),
    .addrLoad(addrLoad), .addrByte(addrByte), .writeStrobe(writeStrobe),
    .writeData(writeData), .readStrobe(readStrobe));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic samples(input int n, input logic [11:0] x, y, z);
    repeat (n) begin
      @(negedge clk);
      {xSample, ySample, zSample} = {x, y, z};
      sampleValid = 1'b1;
      @(negedge clk);
      sampleValid = 1'b0;
    end
  endtask : samples
  task automatic flags(input logic [15:0] e);
    aurb_host_model_i.xfer(4'h0, 2, 1'b0, 8'h00);
    `CHK({aurb_host_model_i.got[0], aurb_host_model_i.got[1]}, e)
  endtask : flags
  task automatic t_reset;
    aurb_host_model_i.xfer(4'h0, 16, 1'b0, 8'h00);
    for (int i = 0; i < 16; i++) `CHK(aurb_host_model_i.got[i], 8'h00)
    aurb_host_model_i.xfer(4'hE, 2, 1'b0, 8'h00);
    `CHK(aurb_host_model_i.got[1], 8'h00)
    $display("test reset done");
  endtask : t_reset
  task automatic t_sample;
    logic [63:0] e;
    e = 64'h13123080_0001209C;
    calibDone = 1'b1;
    tempSample = 8'h9C;
    samples(1, 12'h123, 12'h800, 12'h012);
    flags(16'h0001);
    aurb_host_model_i.xfer(4'h2, 1, 1'b0, 8'h00);
    `CHK(aurb_host_model_i.got[0], 8'h13)
    aurb_host_model_i.xfer(4'h2, 8, 1'b0, 8'h00);
    for (int i = 0; i < 8; i++) `CHK(aurb_host_model_i.got[i], e[63-8*i -: 8])
    $display("test sample done");
  endtask : t_sample
  task automatic t_clear;
    @(negedge clk) shakeDetect = 4'hF;
    @(negedge clk) shakeDetect = 4'h0;
    aurb_host_model_i.xfer(4'h1, 1, 1'b1, 8'h01);
    aurb_host_model_i.xfer(4'h0, 1, 1'b1, 8'h05);
    @(negedge clk) shakeDetect = 4'h3;
    @(negedge clk) shakeDetect = 4'h0;
    flags(16'h0B00);
    $display("test clear done");
  endtask : t_clear
  task automatic t_soft;
    aurb_host_model_i.xfer(4'h1, 1, 1'b1, 8'h10);
    flags(16'h0000);
    $display("test soft reset done");
  endtask : t_soft
  task automatic t_filter;
    samples(15, 12'h000, 12'h800, 12'h012);
    flags(16'h0001);
    samples(1, 12'h000, 12'h800, 12'h012);
    flags(16'h4031);
    samples(16, 12'h010, 12'h010, 12'hC00);
    flags(16'hC0F1);
    $display("test filter done");
  endtask : t_filter
  task automatic t_irq;
    `CHK(irqOutEn, 1'b1)
    `CHK(irqOut, 1'b0)
    aurb_host_model_i.xfer(4'hA, 1, 1'b1, 8'h80);
    `CHK(irqOutEn, 1'b0)
    aurb_host_model_i.xfer(4'h0, 1, 1'b1, 8'hC0);
    `CHK(irqOutEn, 1'b1)
    flags(16'h00F1);
    $display("test irq done");
  endtask : t_irq
  task automatic results;
    $display("checks=%0d mismatches=%0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results
  initial begin
    cycles = 0;
    forever begin
      @(posedge clk);
      cycles++;
      if (cycles == 20000) begin
        miscompares++;
        results();
      end
    end
  end
  initial begin
    {reset_n, sampleValid, calibDone, shakeDetect, tempSample} = 15'h0000;
    {xSample, ySample, zSample} = 36'h0;
    totalChecks = 0;
    miscompares = 0;
    repeat (4) @(negedge clk);
    reset_n = 1'b1;
    t_reset();
    t_sample();
    t_clear();
    t_soft();
    t_filter();
    t_irq();
    results();
  end
endmodule : aurb_register_bank_bench
